//--- eipu_pkg.sv
// Package of register map, fields and constants for the external pin interrupt unit
package eipu_pkg;

  typedef logic [7:0] eipu_byte_t;
  typedef logic [7:0] eipu_addr_t;

  // Register offsets
  localparam eipu_addr_t OFS_MCU_CONTROL        = 8'h00;
  localparam eipu_addr_t OFS_MCU_CONTROL_STATUS = 8'h01;
  localparam eipu_addr_t OFS_PIN_IRQ_ENABLE     = 8'h02;
  localparam eipu_addr_t OFS_PIN_IRQ_FLAGS      = 8'h03;
  localparam eipu_addr_t OFS_PIN_LEVEL          = 8'h04;

  // Field positions in mcu_control
  localparam int SENSE_ZERO_LO_BIT = 0;
  localparam int SENSE_ZERO_HI_BIT = 1;
  localparam int SENSE_ONE_LO_BIT  = 2;
  localparam int SENSE_ONE_HI_BIT  = 3;

  // Field position in mcu_control_status
  localparam int EDGE_POLARITY_TWO_BIT = 6;

  // Enable and pending positions
  localparam int IRQ_LINE_ZERO_BIT = 6;
  localparam int IRQ_LINE_ONE_BIT  = 7;
  localparam int IRQ_LINE_TWO_BIT  = 5;

  // Writable masks
  localparam eipu_byte_t MCU_CONTROL_MASK        = 8'h0f;
  localparam eipu_byte_t MCU_CONTROL_STATUS_MASK = 8'h40;
  localparam eipu_byte_t PIN_IRQ_MASK            = 8'he0;

  // Reset values
  localparam eipu_byte_t MCU_CONTROL_RST        = 8'h00;
  localparam eipu_byte_t MCU_CONTROL_STATUS_RST = 8'h00;
  localparam eipu_byte_t PIN_IRQ_ENABLE_RST     = 8'h00;
  localparam eipu_byte_t PIN_IRQ_FLAGS_RST      = 8'h00;

  // Sense encodings for the first two pins
  typedef enum logic [1:0] {
    SENSE_LOW_LEVEL = 2'b00,
    SENSE_ANY_CHANGE = 2'b01,
    SENSE_FALLING = 2'b10,
    SENSE_RISING = 2'b11
  } eipu_sense_e;

  // Synchroniser depth
  localparam int SYNC_STAGES = 3;

endpackage : eipu_pkg

//--- eipu_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none

module eipu_sync #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  // Asynchronous inputs
  input  wire logic [WIDTH-1:0] async_in,
  // Filtered levels
  output logic      [WIDTH-1:0] level_q
);
  import eipu_pkg::*;

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] mid_q;
  logic [WIDTH-1:0] last_q;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      meta_q <= '0;
      mid_q  <= '0;
      last_q <= '0;
    end else begin
      meta_q <= async_in;
      mid_q  <= meta_q;
      last_q <= mid_q;
    end
  end

  // Level moves once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          level_q[g] <= 1'b0;
        end else if (mid_q[g] == last_q[g]) begin
          level_q[g] <= last_q[g];
        end
      end
    end
  endgenerate

endmodule : eipu_sync

`default_nettype wire

//--- eipu_top.sv
// External pin interrupt unit: sense control, flags, enables and requests
//
// Operation
// - Second pin sense from bits three two
// - First pin sense from bits one zero
// - Sample pins first; catch pulses over two periods
// - Third pin polarity bit six selects edge
// - Third pin edges captured without system clock
// - Second pin enable bit seven plus global
// - First pin enable bit six plus global
// - Third pin enable bit five plus global
// - Pin activity detected even when driven out
// - Each pin has its own request vector
// - Second pin event sets flag bit seven
// - First pin event sets flag bit six
// - Third pin event sets flag bit five
// - Flags clear on service or written one
// - Low level sense holds flag cleared
// - Buffer shutdown change may set third flag
// - Low level request stays while pin low
// - Edges clocked; low level, third edge clockless
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/10ps
`default_nettype none

module eipu_top (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  // Register port
  input  wire eipu_pkg::eipu_addr_t reg_addr,
  input  wire eipu_pkg::eipu_byte_t reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output eipu_pkg::eipu_byte_t  reg_rdata,
  // External pins
  input  wire logic             irq_line_zero,
  input  wire logic             irq_line_one,
  input  wire logic             irq_line_two,
  // Sleep input buffer shutdown of third pin
  input  wire logic             two_buf_off,
  // CPU side
  input  wire logic             cpu_global_ie,
  input  wire logic [2:0]       irq_ack,
  output logic                  irq_req_zero,
  output logic                  irq_req_one,
  output logic                  irq_req_two
);
  import eipu_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  eipu_byte_t mcu_control_q;
  eipu_byte_t mcu_control_status_q;
  eipu_byte_t pin_irq_enable_q;
  eipu_byte_t pin_irq_flags_q;
  eipu_byte_t reg_rdata_q;

  logic       wr_control;
  logic       wr_status;
  logic       wr_enable;
  logic       wr_flags;

  assign wr_control = reg_wr && (reg_addr == OFS_MCU_CONTROL);
  assign wr_status  = reg_wr && (reg_addr == OFS_MCU_CONTROL_STATUS);
  assign wr_enable  = reg_wr && (reg_addr == OFS_PIN_IRQ_ENABLE);
  assign wr_flags   = reg_wr && (reg_addr == OFS_PIN_IRQ_FLAGS);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mcu_control_q <= MCU_CONTROL_RST;
    end else if (wr_control) begin
      mcu_control_q <= reg_wdata & MCU_CONTROL_MASK;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mcu_control_status_q <= MCU_CONTROL_STATUS_RST;
    end else if (wr_status) begin
      mcu_control_status_q <= reg_wdata & MCU_CONTROL_STATUS_MASK;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pin_irq_enable_q <= PIN_IRQ_ENABLE_RST;
    end else if (wr_enable) begin
      pin_irq_enable_q <= reg_wdata & PIN_IRQ_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sense selects
  eipu_sense_e sense [2];
  logic        polarity_two;

  assign sense[0] = eipu_sense_e'({mcu_control_q[SENSE_ZERO_HI_BIT],
                                   mcu_control_q[SENSE_ZERO_LO_BIT]});
  assign sense[1] = eipu_sense_e'({mcu_control_q[SENSE_ONE_HI_BIT],
                                   mcu_control_q[SENSE_ONE_LO_BIT]});
  assign polarity_two = mcu_control_status_q[EDGE_POLARITY_TWO_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Third pin: clockless edge capture
  logic two_seen;
  logic two_trig;
  logic two_toggle_q;

  // Buffer shutdown forces the seen level low
  assign two_seen = irq_line_two & ~two_buf_off;
  // Falling edge when polarity zero, rising when one
  assign two_trig = two_seen ^ ~polarity_two;

  // Toggles on the chosen edge, no system clock needed
  always_ff @(posedge two_trig or posedge sys_rst) begin
    if (sys_rst) begin
      two_toggle_q <= 1'b0;
    end else begin
      two_toggle_q <= ~two_toggle_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers
  logic [2:0] sync_level;
  logic [2:0] prev_q;
  logic [2:0] raw_in;

  // Pad input seen regardless of output driver state
  assign raw_in = {two_toggle_q, irq_line_one, irq_line_zero};

  eipu_sync #(
    .WIDTH    (3)
  ) u_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in (raw_in),
    .level_q  (sync_level)
  );

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prev_q <= '0;
    end else begin
      prev_q <= sync_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge events for the first two pins
  logic [1:0] edge_evt;
  logic [1:0] level_mode;

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_pin
      logic rise;
      logic fall;
      assign rise = sync_level[p] & ~prev_q[p];
      assign fall = ~sync_level[p] & prev_q[p];
      assign level_mode[p] = (sense[p] == SENSE_LOW_LEVEL);
      always_comb begin
        unique case (sense[p])
          SENSE_LOW_LEVEL:  edge_evt[p] = 1'b0;
          SENSE_ANY_CHANGE: edge_evt[p] = rise | fall;
          SENSE_FALLING:    edge_evt[p] = fall;
          SENSE_RISING:     edge_evt[p] = rise;
        endcase
      end
    end
  endgenerate

  // Third pin event from toggle change
  logic two_evt;
  assign two_evt = sync_level[2] ^ prev_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // Flags: set wins over clear
  logic [7:0] set_vec;
  logic [7:0] clr_vec;

  always_comb begin
    set_vec = '0;
    clr_vec = '0;
    set_vec[IRQ_LINE_ONE_BIT]  = edge_evt[1];
    set_vec[IRQ_LINE_ZERO_BIT] = edge_evt[0];
    set_vec[IRQ_LINE_TWO_BIT]  = two_evt;
    clr_vec[IRQ_LINE_ZERO_BIT] = irq_ack[0];
    clr_vec[IRQ_LINE_ONE_BIT]  = irq_ack[1];
    clr_vec[IRQ_LINE_TWO_BIT]  = irq_ack[2];
    if (wr_flags) begin
      clr_vec = clr_vec | (reg_wdata & PIN_IRQ_MASK);
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pin_irq_flags_q <= PIN_IRQ_FLAGS_RST;
    end else begin
      pin_irq_flags_q <= ((pin_irq_flags_q & ~clr_vec) | set_vec) & PIN_IRQ_MASK;
      if (level_mode[0]) begin
        pin_irq_flags_q[IRQ_LINE_ZERO_BIT] <= 1'b0;
      end
      if (level_mode[1]) begin
        pin_irq_flags_q[IRQ_LINE_ONE_BIT] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Requests, one per vector
  logic en_zero;
  logic en_one;
  logic en_two;

  assign en_zero = pin_irq_enable_q[IRQ_LINE_ZERO_BIT] & cpu_global_ie;
  assign en_one  = pin_irq_enable_q[IRQ_LINE_ONE_BIT] & cpu_global_ie;
  assign en_two  = pin_irq_enable_q[IRQ_LINE_TWO_BIT] & cpu_global_ie;

  // Low level taken straight from the pad, clockless
  assign irq_req_zero = en_zero & (level_mode[0] ? ~irq_line_zero
                                   : pin_irq_flags_q[IRQ_LINE_ZERO_BIT]);
  assign irq_req_one  = en_one & (level_mode[1] ? ~irq_line_one
                                  : pin_irq_flags_q[IRQ_LINE_ONE_BIT]);
  assign irq_req_two  = en_two & pin_irq_flags_q[IRQ_LINE_TWO_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Read port, data valid one cycle after strobe
  eipu_byte_t rd_mux;

  always_comb begin
    rd_mux = '0;
    unique case (reg_addr)
      OFS_MCU_CONTROL:        rd_mux = mcu_control_q;
      OFS_MCU_CONTROL_STATUS: rd_mux = mcu_control_status_q;
      OFS_PIN_IRQ_ENABLE:     rd_mux = pin_irq_enable_q;
      OFS_PIN_IRQ_FLAGS:      rd_mux = pin_irq_flags_q;
      OFS_PIN_LEVEL:          rd_mux = {2'b00, irq_req_two, irq_req_one, irq_req_zero,
                                        sync_level};
      default:                rd_mux = '0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata_q <= '0;
    end else if (reg_rd) begin
      reg_rdata_q <= rd_mux;
    end else begin
      reg_rdata_q <= '0;
    end
  end

  assign reg_rdata = reg_rdata_q;

endmodule : eipu_top

`default_nettype wire

//--- eipu_monitor.sv
// Checker of register port, request gating and level sensing
`timescale 1ns/10ps
`default_nettype none

module eipu_monitor (
  // Clock and reset
  input wire logic                 core_clk,
  input wire logic                 sys_rst,
  // Register port
  input wire eipu_pkg::eipu_addr_t reg_addr,
  input wire eipu_pkg::eipu_byte_t reg_wdata,
  input wire logic                 reg_wr,
  input wire logic                 reg_rd,
  input wire eipu_pkg::eipu_byte_t reg_rdata,
  // Pins and CPU side
  input wire logic                 irq_line_zero,
  input wire logic                 irq_line_one,
  input wire logic                 cpu_global_ie,
  input wire logic                 irq_req_zero,
  input wire logic                 irq_req_one,
  input wire logic                 irq_req_two
);
  import eipu_pkg::*;
  logic [3:0] sns_q;
  eipu_byte_t en_q;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////
  // Shadow of sense and enable registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) sns_q <= 4'h0;
    else if (reg_wr && reg_addr == OFS_MCU_CONTROL) sns_q <= reg_wdata[3:0];
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) en_q <= 8'h00;
    else if (reg_wr && reg_addr == OFS_PIN_IRQ_ENABLE) en_q <= reg_wdata & PIN_IRQ_MASK;
  end
  sequence s_lvl0; sns_q[1:0] == 2'b00 ##1 sns_q[1:0] == 2'b00; endsequence
  sequence s_lvl1; sns_q[3:2] == 2'b00 ##1 sns_q[3:2] == 2'b00; endsequence
  ////////////////////////////////////////////////////////////////////
  // Assertions
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  a_sense_readback: assert property (reg_rd && reg_addr == OFS_MCU_CONTROL
    |=> reg_rdata == {4'h0, sns_q}) else $error("sense readback wrong");
  a_enable_readback: assert property (reg_rd && reg_addr == OFS_PIN_IRQ_ENABLE
    |=> reg_rdata == en_q) else $error("enable readback wrong");
  a_req_one_gate: assert property (irq_req_one
    |-> cpu_global_ie && en_q[IRQ_LINE_ONE_BIT]) else $error("pin one request ungated");
  a_req_zero_gate: assert property (irq_req_zero
    |-> cpu_global_ie && en_q[IRQ_LINE_ZERO_BIT]) else $error("pin zero request ungated");
  a_req_two_gate: assert property (irq_req_two
    |-> cpu_global_ie && en_q[IRQ_LINE_TWO_BIT]) else $error("pin two request ungated");
  a_level_zero_on: assert property (s_lvl0 ##0 (!irq_line_zero && cpu_global_ie
    && en_q[IRQ_LINE_ZERO_BIT]) |-> irq_req_zero) else $error("low level not requested");
  a_level_zero_off: assert property (s_lvl0 ##0 irq_line_zero |-> !irq_req_zero)
    else $error("pin zero request while high");
  a_level_one_off: assert property (s_lvl1 ##0 irq_line_one |-> !irq_req_one)
    else $error("pin one request while high");
  a_level_one_on: assert property (s_lvl1 ##0 (!irq_line_one && cpu_global_ie
    && en_q[IRQ_LINE_ONE_BIT]) |-> irq_req_one) else $error("pin one low level not requested");
endmodule : eipu_monitor

`default_nettype wire

//--- eipu_pin_src.sv
// Board-level sources driving the three interrupt pins
`timescale 1ns/10ps
`default_nettype none

module eipu_pin_src (
  // Pin levels
  output var logic [2:0] pin_lvl
);
  initial pin_lvl = 3'b111;
  // Level holds until the next call, off the clock edge
  task automatic drive(input int idx, input logic v);
    #3;
    pin_lvl[idx] = v;
  endtask : drive
endmodule : eipu_pin_src

`default_nettype wire

//--- testbench.sv
// Self-checking bench of the external pin interrupt unit
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import eipu_pkg::*;
  logic core_clk = 1'b0, sys_rst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic two_buf_off = 1'b0, cpu_global_ie = 1'b0, pre;
  logic [2:0] irq_ack = 3'h0;
  eipu_addr_t reg_addr = 8'h00;
  eipu_byte_t reg_wdata = 8'h00;
  eipu_byte_t reg_rdata;
  wire logic [2:0] pin_lvl;
  wire logic irq_req_zero, irq_req_one, irq_req_two;
  wire logic [2:0] req = {irq_req_two, irq_req_one, irq_req_zero};
  int err_total = 0, total_checks = 0;
  always #12.5 core_clk = ~core_clk;
  eipu_pin_src pins (.pin_lvl(pin_lvl));
  eipu_top uut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq_line_zero(pin_lvl[0]), .irq_line_one(pin_lvl[1]), .irq_line_two(pin_lvl[2]),
    .two_buf_off(two_buf_off), .cpu_global_ie(cpu_global_ie), .irq_ack(irq_ack),
    .irq_req_zero(irq_req_zero), .irq_req_one(irq_req_one), .irq_req_two(irq_req_two));
  ////////////////////////////////////////////////////////////////////
  // Access tasks
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string n, input eipu_byte_t e, input eipu_byte_t s);
    total_checks++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, s);
      err_total++;
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  task automatic wr(input eipu_addr_t a, input eipu_byte_t d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input eipu_addr_t a, input eipu_byte_t e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", e, reg_rdata);
  endtask : rd
  task automatic wait_req(input int i);
    for (int k = 0; k < 30; k++) begin
      @(posedge core_clk);
      #1 if (req[i] === 1'b1) return;
    end
    $display("wrong value irq_req expected 1 seen timeout");
    err_total++;
    final_report();
  endtask : wait_req
  ////////////////////////////////////////////////////////////////////
  // Scenarios
  initial begin
    // Rising reset edge also clears the clockless pin-two flop
    sys_rst <= 1'b1;
    cyc(16);
    sys_rst <= 1'b0;
    for (int a = 0; a < 5; a++) rd(a == 4 ? 8'h10 : a[7:0], 8'h00);
    cpu_global_ie <= 1'b1;
    wr(OFS_PIN_IRQ_ENABLE, 8'he0);
    for (int m = 1; m < 4; m++) begin
      pre = (m == 2);
      wr(OFS_MCU_CONTROL, {4'h0, m[1:0], m[1:0]});
      rd(OFS_MCU_CONTROL, {4'h0, m[1:0], m[1:0]});
      pins.drive(0, pre);
      pins.drive(1, pre);
      cyc(8);
      wr(OFS_PIN_IRQ_FLAGS, 8'hc0);
      rd(OFS_PIN_IRQ_FLAGS, 8'h00);
      pins.drive(0, !pre);
      pins.drive(1, !pre);
      wait_req(0);
      wait_req(1);
      rd(OFS_PIN_IRQ_FLAGS, 8'hc0);
    end
    wr(OFS_MCU_CONTROL, 8'h0c);
    rd(OFS_PIN_IRQ_FLAGS, 8'h80);
    wr(OFS_MCU_CONTROL, 8'h0f);
    wr(OFS_PIN_IRQ_FLAGS, 8'hc0);
    pins.drive(0, 1'b0);
    pins.drive(1, 1'b0);
    cyc(8);
    rd(OFS_PIN_IRQ_FLAGS, 8'h00);
    cpu_global_ie <= 1'b0;
    pins.drive(0, 1'b1);
    pins.drive(1, 1'b1);
    cyc(8);
    chk("irq_req", 8'h00, {5'h0, req});
    wr(OFS_PIN_IRQ_FLAGS, 8'h00);
    rd(OFS_PIN_IRQ_FLAGS, 8'hc0);
    cpu_global_ie <= 1'b1;
    irq_ack <= 3'b011;
    @(posedge core_clk) irq_ack <= 3'b000;
    rd(OFS_PIN_IRQ_FLAGS, 8'h00);
    wr(OFS_MCU_CONTROL, 8'h00);
    pins.drive(0, 1'b0);
    pins.drive(1, 1'b0);
    cyc(2);
    chk("irq_req", 8'h03, {5'h0, req});
    rd(OFS_PIN_IRQ_FLAGS, 8'h00);
    pins.drive(0, 1'b1);
    pins.drive(1, 1'b1);
    // Filtered levels settle before edge sensing returns
    cyc(8);
    chk("irq_req", 8'h00, {5'h0, req});
    wr(OFS_MCU_CONTROL, 8'h0f);
    wr(OFS_MCU_CONTROL_STATUS, 8'h00);
    pins.drive(2, 1'b0);
    wait_req(2);
    chk("irq_req", 8'h04, {5'h0, req});
    rd(OFS_PIN_IRQ_FLAGS, 8'h20);
    wr(OFS_PIN_IRQ_ENABLE, 8'hc0);
    wr(OFS_MCU_CONTROL_STATUS, 8'h40);
    rd(OFS_MCU_CONTROL_STATUS, 8'h40);
    cyc(8);
    wr(OFS_PIN_IRQ_FLAGS, 8'h20);
    wr(OFS_PIN_IRQ_ENABLE, 8'he0);
    rd(OFS_PIN_IRQ_FLAGS, 8'h00);
    pins.drive(2, 1'b1);
    wait_req(2);
    irq_ack <= 3'b100;
    @(posedge core_clk) irq_ack <= 3'b000;
    rd(OFS_PIN_IRQ_FLAGS, 8'h00);
    two_buf_off <= 1'b1;
    cyc(8);
    two_buf_off <= 1'b0;
    cyc(8);
    rd(OFS_PIN_IRQ_FLAGS, 8'h20);
    final_report();
  end
endmodule : testbench

bind eipu_top eipu_monitor mon (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .irq_line_zero(irq_line_zero), .irq_line_one(irq_line_one), .cpu_global_ie(cpu_global_ie),
  .irq_req_zero(irq_req_zero), .irq_req_one(irq_req_one), .irq_req_two(irq_req_two));

`default_nettype wire
